// ==== logic/fcl_consts.svh ====
// Purpose: offsets, field positions and timing counts of the fuse loader
// Assumes: included by bare name from the package and the loader
// Notes:   fuse offsets are printed byte indices, word address is 4x
`ifndef FCL_CONSTS_SVH
`define FCL_CONSTS_SVH

// ---------------------------------------------------------------
// fuse indices
// ---------------------------------------------------------------
`define FCL_IDX_WDOG        4'h0
`define FCL_IDX_BROWN       4'h1
`define FCL_IDX_OSC         4'h2
`define FCL_IDX_SYS_A       4'h5
`define FCL_IDX_SYS_B       4'h6
`define FCL_IDX_APP_END     4'h7
`define FCL_IDX_BOOT_END    4'h8
`define FCL_IDX_KEY         4'ha
`define FCL_NUM_FUSES       11
`define FCL_IDX_STATUS      4'hc
`define FCL_IDX_WRITE       4'hd

// ---------------------------------------------------------------
// field positions and codes
// ---------------------------------------------------------------
`define FCL_SLEEP_RESERVED  2'h3
`define FCL_FREQ_16         2'h1
`define FCL_FREQ_20         2'h2
`define FCL_PIN_GPIO        2'h0
`define FCL_UNLOCK_KEY      8'hc5
`define FCL_ERASED          8'hff

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define FCL_CLK_HZ          100_000_000
`define FCL_SLOW_HZ         32_768
`define FCL_PIN_HOLD_TICKS  768
`define FCL_STARTUP_UNIT_MS 1
`define FCL_CYC_PER_MS      ((`FCL_CLK_HZ / 1000) * `FCL_STARTUP_UNIT_MS)
`define FCL_SLOW_DIV        ((`FCL_CLK_HZ + `FCL_SLOW_HZ - 1) / `FCL_SLOW_HZ)

`endif

// ==== logic/fcl_pkg.sv ====
// Purpose: types shared by the fuse loader
// Assumes: fcl_consts.svh holds the numbers
// Notes:   none
`include "fcl_consts.svh"

package fcl_pkg;

  typedef struct packed {
    logic [3:0] window;
    logic [3:0] period;
  } fcl_wdog_s;

  typedef struct packed {
    logic [2:0] threshold;
    logic       sample_rate;
    logic [1:0] active_mode;
    logic [1:0] sleep_mode;
  } fcl_brown_s;

  typedef struct packed {
    logic [7:0] freq_trim;
    logic [7:0] temp_trim;
    logic       calibration_lock;
    logic [1:0] freq_choice;
  } fcl_osc_s;

  typedef enum logic [2:0] {
    FCL_ST_READ,
    FCL_ST_APPLY,
    FCL_ST_DELAY,
    FCL_ST_RUN
  } fcl_state_e;

endpackage : fcl_pkg

// ==== logic/fcl_loader.sv ====
// Purpose: copies fuse bytes into peripheral controls during reset
// Assumes: one 100 MHz clock, AHB-Lite slave for fuse access
// Notes:   fuse writes go to the store only; live values wait for reset
//
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "fcl_consts.svh"

// Overview of operation
// - watchdog fuse high nibble loads the watchdog window field at reset
// - watchdog fuse low nibble loads the watchdog period field at reset
// - brown-out fuse top three bits load the threshold field at reset
// - brown-out sample-rate bit copied: 0 is 1 kHz, 1 is 125 Hz
// - active/idle brown-out mode, two bits, copied at reset
// - sleep brown-out mode copied; reserved code 3 never produced
// - oscillator fuse top bit sets the calibration lock at reset
// - frequency choice 1 runs 16 MHz, 2 runs 20 MHz, others reserved
// - factory trims matching the chosen frequency load the trim fields
// - boot check scope: whole, boot, boot plus code, or none
// - shared pin function: gpio, debug port or reset input
// - gpio pin driver held off 768 slow-oscillator cycles after reset
// - retention bit 0 erases EEPROM on chip erase, 1 keeps it
// - locked device always erases EEPROM on chip erase
// - changed fuses take effect only after the next reset
// - start-up delay code doubles from 1 ms to 64 ms, 0 none
// - section limits in 256-byte blocks; both zero means all boot
// - access key 0xC5 unlocks memory, any other value locks
module fcl_loader
  import fcl_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = `FCL_CYC_PER_MS,
  parameter int unsigned SLOW_DIV   = `FCL_SLOW_DIV,
  parameter logic [7:0]  TRIM16_F   = 8'h00,
  parameter logic [7:0]  TRIM16_T   = 8'h00,
  parameter logic [7:0]  TRIM20_F   = 8'h00,
  parameter logic [7:0]  TRIM20_T   = 8'h00
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // chip erase request
  input  wire logic        chip_erase,
  output logic             eeprom_erase,
  // peripheral destinations
  output fcl_wdog_s        wdog_ctrl,
  output fcl_brown_s       brown_ctrl,
  output fcl_osc_s         osc_ctrl,
  output logic [1:0]       boot_check_scope,
  output logic [1:0]       shared_pin_function,
  output logic             pin_driver_allowed,
  output logic [7:0]       app_section_limit,
  output logic [7:0]       boot_section_limit,
  output logic             whole_flash_boot,
  output logic             memory_locked,
  output logic             cpu_release
);

  // ---------------------------------------------------------------
  // fuse store: survives reset, only the bus changes it
  // ---------------------------------------------------------------
  logic [7:0] store_q [`FCL_NUM_FUSES];
  logic [7:0] live_q  [`FCL_NUM_FUSES];

  fcl_state_e  state_q;
  logic [3:0]  rd_idx_q;
  logic [31:0] delay_q;
  logic [9:0]  slow_cnt_q;
  logic [15:0] div_q;
  logic        pin_hold_q;
  logic        wr_pend_q;
  logic [3:0]  wr_idx_q;
  logic [31:0] hrdata_q;
  logic        erase_q;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire       bus_go    = hsel & hready & htrans[1];
  wire [3:0] bus_idx   = haddr[5:2];
  wire       idx_fuse  = bus_idx < 4'(`FCL_NUM_FUSES);
  wire       is_status = bus_idx == `FCL_IDX_STATUS;
  wire [7:0] rd_fuse   = idx_fuse ? store_q[bus_idx] : 8'h00;
  wire [31:0] status_w = {24'h0000_00, 5'h00, pin_hold_q, memory_locked,
                          cpu_release};
  wire [31:0] rd_word  = is_status ? status_w : {24'h0000_00, rd_fuse};

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_idx_q  <= 4'h0;
      hrdata_q  <= 32'h0000_0000;
    end else begin
      wr_pend_q <= bus_go & hwrite & idx_fuse;
      wr_idx_q  <= bus_idx;
      if (bus_go && !hwrite) begin
        hrdata_q <= rd_word;
      end
    end
  end

  // writes land in the store only, never in live copies
  always_ff @(posedge hclk) begin
    if (wr_pend_q) begin
      store_q[wr_idx_q] <= hwdata[7:0];
    end
  end

  // ---------------------------------------------------------------
  // reset-time sequence
  // ---------------------------------------------------------------
  wire [7:0] sys_b   = live_q[`FCL_IDX_SYS_B];
  wire [2:0] power_on_delay_select     = sys_b[2:0];
  // code n>0 gives 2^(n-1) ms
  wire [31:0] delay_ld = (power_on_delay_select == 3'h0) ? 32'h0000_0000 :
                         32'(CYC_PER_MS << (power_on_delay_select - 3'h1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q  <= FCL_ST_READ;
      rd_idx_q <= 4'h0;
      delay_q  <= 32'h0000_0000;
    end else begin
      case (state_q)
        FCL_ST_READ: begin
          // each fuse copied once per reset
          live_q[rd_idx_q] <= store_q[rd_idx_q];
          rd_idx_q <= rd_idx_q + 4'h1;
          if (rd_idx_q == 4'(`FCL_NUM_FUSES - 1)) begin
            state_q <= FCL_ST_APPLY;
          end
        end
        FCL_ST_APPLY: begin
          delay_q <= delay_ld;
          state_q <= FCL_ST_DELAY;
        end
        FCL_ST_DELAY: begin
          if (delay_q == 32'h0000_0000) begin
            state_q <= FCL_ST_RUN;
          end else begin
            delay_q <= delay_q - 32'h0000_0001;
          end
        end
        FCL_ST_RUN: begin
          state_q <= FCL_ST_RUN;
        end
        default: begin
          state_q <= FCL_ST_READ;
        end
      endcase
    end
  end

  wire loaded = (state_q == FCL_ST_DELAY) | (state_q == FCL_ST_RUN);
  // processor held until fuses are applied and delay is over
  assign cpu_release = state_q == FCL_ST_RUN;

  // ---------------------------------------------------------------
  // destinations, zero until loaded except osc_ctrl (20 MHz), memory_locked and whole_flash_boot
  // ---------------------------------------------------------------
  wire [7:0] wd = loaded ? live_q[`FCL_IDX_WDOG]  : 8'h00;
  wire [7:0] bd = loaded ? live_q[`FCL_IDX_BROWN] : 8'h00;
  wire [7:0] od = loaded ? live_q[`FCL_IDX_OSC]   : 8'h00;
  wire [7:0] sa = loaded ? live_q[`FCL_IDX_SYS_A] : 8'h00;
  wire [1:0] fsel = od[1:0];

  assign wdog_ctrl.window = wd[7:4];
  assign wdog_ctrl.period = wd[3:0];
  assign brown_ctrl.threshold   = bd[7:5];
  assign brown_ctrl.sample_rate = bd[4];
  assign brown_ctrl.active_mode = bd[3:2];
  // reserved sleep code falls back to disabled
  assign brown_ctrl.sleep_mode  =
    (bd[1:0] == `FCL_SLEEP_RESERVED) ? 2'h0 : bd[1:0];
  assign osc_ctrl.calibration_lock = od[7];
  // reserved frequency codes run at 20 MHz
  assign osc_ctrl.freq_choice =
    (fsel == `FCL_FREQ_16) ? `FCL_FREQ_16 : `FCL_FREQ_20;
  assign osc_ctrl.freq_trim =
    (fsel == `FCL_FREQ_16) ? TRIM16_F : TRIM20_F;
  assign osc_ctrl.temp_trim =
    (fsel == `FCL_FREQ_16) ? TRIM16_T : TRIM20_T;
  assign boot_check_scope    = sa[7:6];
  // reserved pin code treated as reset input, the safe choice
  assign shared_pin_function = (sa[3:2] == 2'h3) ? 2'h2 : sa[3:2];

  assign app_section_limit  = loaded ? live_q[`FCL_IDX_APP_END]  : 8'h00;
  assign boot_section_limit = loaded ? live_q[`FCL_IDX_BOOT_END] : 8'h00;
  // limits are 256-byte blocks; zero pair makes all flash boot
  assign whole_flash_boot = (app_section_limit == 8'h00) &
                            (boot_section_limit == 8'h00);
  // locked until the valid key has been loaded
  assign memory_locked = ~loaded |
                         (live_q[`FCL_IDX_KEY] != `FCL_UNLOCK_KEY);

  // ---------------------------------------------------------------
  // gpio driver hold on slow-oscillator ticks
  // ---------------------------------------------------------------
  wire slow_tick = div_q == 16'(SLOW_DIV - 1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_q      <= 16'h0000;
      slow_cnt_q <= 10'h000;
      pin_hold_q <= 1'b1;
    end else begin
      div_q <= slow_tick ? 16'h0000 : div_q + 16'h0001;
      if (slow_tick && pin_hold_q) begin
        slow_cnt_q <= slow_cnt_q + 10'h001;
        // driver off for 768 ticks after every reset
        if (slow_cnt_q == 10'(`FCL_PIN_HOLD_TICKS - 1)) begin
          pin_hold_q <= 1'b0;
        end
      end
    end
  end

  assign pin_driver_allowed = loaded & ~pin_hold_q &
                              (shared_pin_function == `FCL_PIN_GPIO);

  // ---------------------------------------------------------------
  // chip erase decision
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      erase_q <= 1'b0;
    end else begin
      // locked wins over retention else bit 0
      erase_q <= chip_erase & (memory_locked | ~sa[0]);
    end
  end
  assign eeprom_erase = erase_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence run_s;
    state_q == FCL_ST_RUN;
  endsequence

  wdog_copy_a: assert property (@(posedge hclk) disable iff (!hresetn)
    loaded |-> wdog_ctrl == live_q[`FCL_IDX_WDOG])
    else $error("watchdog fields differ from fuse");
  wdog_period_a: assert property (@(posedge hclk) disable iff (!hresetn)
    loaded |-> wdog_ctrl.period == live_q[`FCL_IDX_WDOG][3:0])
    else $error("watchdog period differs from fuse");
  brown_copy_a: assert property (@(posedge hclk) disable iff (!hresetn)
    loaded |-> brown_ctrl.threshold == live_q[`FCL_IDX_BROWN][7:5] &&
    brown_ctrl.sample_rate == live_q[`FCL_IDX_BROWN][4])
    else $error("brown-out threshold or rate wrong");
  brown_active_a: assert property (@(posedge hclk) disable iff (!hresetn)
    loaded |-> brown_ctrl.active_mode == live_q[`FCL_IDX_BROWN][3:2])
    else $error("active mode wrong");
  sleep_code_a: assert property (@(posedge hclk) disable iff (!hresetn)
    brown_ctrl.sleep_mode != `FCL_SLEEP_RESERVED)
    else $error("reserved sleep code produced");
  osc_lock_a: assert property (@(posedge hclk) disable iff (!hresetn)
    loaded |-> osc_ctrl.calibration_lock == live_q[`FCL_IDX_OSC][7])
    else $error("calibration lock wrong");
  freq_trim_a: assert property (@(posedge hclk) disable iff (!hresetn)
    osc_ctrl.freq_choice == `FCL_FREQ_16 |-> osc_ctrl.freq_trim == TRIM16_F)
    else $error("trim does not match frequency");
  pin_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    pin_hold_q |-> !pin_driver_allowed)
    else $error("gpio driver enabled during hold");
  erase_lock_a: assert property (@(posedge hclk) disable iff (!hresetn)
    chip_erase && memory_locked |=> eeprom_erase)
    else $error("locked erase kept eeprom");
  live_stable_a: assert property (@(posedge hclk) disable iff (!hresetn)
    run_s ##1 run_s |-> $stable(live_q[`FCL_IDX_WDOG]))
    else $error("live fuse changed without reset");
  key_lock_a: assert property (@(posedge hclk) disable iff (!hresetn)
    loaded && live_q[`FCL_IDX_KEY] == `FCL_UNLOCK_KEY |-> !memory_locked)
    else $error("valid key left device locked");

  sequence apply_s;
    state_q == FCL_ST_APPLY;
  endsequence

  brown_rate_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    loaded |-> brown_ctrl.sample_rate == live_q[`FCL_IDX_BROWN][4])
    else $error("brown-out sample rate differs from fuse");
  freq_legal_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    osc_ctrl.freq_choice == `FCL_FREQ_16 ||
    osc_ctrl.freq_choice == `FCL_FREQ_20)
    else $error("reserved frequency code produced");
  freq_keep_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    loaded && live_q[`FCL_IDX_OSC][1:0] == `FCL_FREQ_16 |->
    osc_ctrl.freq_choice == `FCL_FREQ_16)
    else $error("lower frequency choice not kept");
  trim20_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    osc_ctrl.freq_choice == `FCL_FREQ_20 |->
    osc_ctrl.freq_trim == TRIM20_F && osc_ctrl.temp_trim == TRIM20_T)
    else $error("upper frequency trims not loaded");
  scope_copy_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    loaded |-> boot_check_scope == live_q[`FCL_IDX_SYS_A][7:6])
    else $error("boot check scope differs from fuse");
  pin_legal_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    shared_pin_function != 2'h3)
    else $error("reserved pin function produced");
  pin_copy_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    loaded && live_q[`FCL_IDX_SYS_A][3:2] != 2'h3 |->
    shared_pin_function == live_q[`FCL_IDX_SYS_A][3:2])
    else $error("pin function differs from fuse");
  erase_keep_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    chip_erase && !memory_locked && live_q[`FCL_IDX_SYS_A][0] |=>
    !eeprom_erase)
    else $error("unlocked erase dropped retained eeprom");
  erase_drop_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    chip_erase && loaded && !live_q[`FCL_IDX_SYS_A][0] |=> eeprom_erase)
    else $error("erase without retention kept eeprom");
  delay_none_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    apply_s ##0 (power_on_delay_select == 3'h0) |-> ##2 run_s)
    else $error("zero start-up code still delayed");
  delay_bound_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    state_q == FCL_ST_DELAY |-> delay_q <= 32'(CYC_PER_MS << 6))
    else $error("start-up delay above longest code");
  boot_all_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    loaded && live_q[`FCL_IDX_APP_END] == 8'h00 &&
    live_q[`FCL_IDX_BOOT_END] == 8'h00 |-> whole_flash_boot)
    else $error("zero limits did not make all flash boot");
  hold_release_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !loaded |-> !cpu_release && memory_locked)
    else $error("released or unlocked before fuses applied");

endmodule : fcl_loader
`default_nettype wire

// ==== sim/fcl_periph_model.sv ====
// Purpose: stand-in for the peripherals that take the loaded settings
// Assumes: settings are valid once cpu_release is high
// Notes:   copies the watchdog value every cycle while released; gates pin interrupts
`timescale 1ns/1ps
`default_nettype none
module fcl_periph_model
  import fcl_pkg::*;
(
  // clock and reset
  input  wire logic      hclk,
  input  wire logic      hresetn,
  // loader outputs
  input  wire logic      cpu_release,
  input  wire logic      pin_driver_allowed,
  input  wire fcl_wdog_s wdog_ctrl,
  // observed state
  output fcl_wdog_s      cfg_wdog,
  output logic           pin_irq_en
);
  // software view: interrupts on the shared pin wait for the hold to end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_wdog   <= 8'h00;
      pin_irq_en <= 1'b0;
    end else begin
      if (cpu_release) cfg_wdog <= wdog_ctrl;
      pin_irq_en <= cpu_release & pin_driver_allowed;
    end
  end
endmodule : fcl_periph_model
`default_nettype wire

// ==== sim/tb_fcl_loader.sv ====
// Purpose: self-checking bench for the fuse loader
// Assumes: zero-wait AHB-Lite slave, short delay parameters
// Notes:   fuses written over the bus, then reset applies them
`timescale 1ns/1ps
`default_nettype none
module tb_fcl_loader;
  import fcl_pkg::*;
  typedef struct packed {
    logic [7:0] wd, bo, os, sa, ky;
    logic [1:0] sl, fq, pn;
    logic       lk, er;
  } fcl_row_s;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, chip_erase = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  logic hreadyout, hresp, eeprom_erase, pin_driver_allowed, cpu_release;
  logic whole_flash_boot, memory_locked, pin_irq_en;
  logic [1:0] boot_check_scope, shared_pin_function;
  logic [7:0] app_section_limit, boot_section_limit, k;
  fcl_wdog_s wdog_ctrl, cfg_wdog;
  fcl_brown_s brown_ctrl;
  fcl_osc_s osc_ctrl;
  int errors = 0, checks = 0, n, m, base;
  fcl_row_s rows [4] = '{
    '{8'ha5, 8'h5b, 8'h81, 8'h09, 8'hc5, 2'h0, 2'h1, 2'h2, 1'b0, 1'b0},
    '{8'h3c, 8'he6, 8'h02, 8'h44, 8'h00, 2'h2, 2'h2, 2'h1, 1'b1, 1'b1},
    '{8'h00, 8'h0d, 8'h03, 8'h8d, 8'hc4, 2'h1, 2'h2, 2'h2, 1'b1, 1'b1},
    '{8'hff, 8'h30, 8'h00, 8'hc0, 8'hc5, 2'h0, 2'h2, 2'h0, 1'b0, 1'b1}};
  always #5 hclk = ~hclk;
  // upper frequency temperature trim left at its default of zero
  fcl_loader #(.CYC_PER_MS(4), .SLOW_DIV(2), .TRIM16_F(8'h1a),
    .TRIM16_T(8'h2b), .TRIM20_F(8'h3c)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .chip_erase(chip_erase), .eeprom_erase(eeprom_erase),
    .wdog_ctrl(wdog_ctrl), .brown_ctrl(brown_ctrl), .osc_ctrl(osc_ctrl),
    .boot_check_scope(boot_check_scope),
    .shared_pin_function(shared_pin_function),
    .pin_driver_allowed(pin_driver_allowed),
    .app_section_limit(app_section_limit),
    .boot_section_limit(boot_section_limit),
    .whole_flash_boot(whole_flash_boot), .memory_locked(memory_locked),
    .cpu_release(cpu_release));
  fcl_periph_model u_model (.hclk(hclk), .hresetn(hresetn),
    .cpu_release(cpu_release), .pin_driver_allowed(pin_driver_allowed),
    .wdog_ctrl(wdog_ctrl), .cfg_wdog(cfg_wdog), .pin_irq_en(pin_irq_en));
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  task automatic hwait;
    int t;
    t = 0;
    do begin
      @(posedge hclk);
      t++;
    end while (hreadyout !== 1'b1 && t < 50);
    if (t >= 50) chk("hready", 1, 0);
  endtask : hwait
  task automatic ahb(input logic w, input logic [3:0] idx,
                     input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {26'h0, idx, 2'b00};
    hwrite <= w;
    hwait();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    hwait();
    rd = hrdata;
    chk("hresp", 0, hresp);
  endtask : ahb
  // reset pulse, then count edges until the processor is let go
  task automatic rst(output int c);
    @(posedge hclk) hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    #1;
    chk("rel_rst", 0, cpu_release);
    chk("lock_rst", 1, memory_locked);
    @(posedge hclk) hresetn <= 1'b1;
    c = 0;
    while (cpu_release !== 1'b1 && c < 1000) begin
      @(posedge hclk);
      c++;
    end
    if (c >= 1000) chk("release", 1, 0);
    #1;
  endtask : rst
  initial begin
    repeat (60000) @(posedge hclk);
    errors++;
    give_verdict();
  end
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rows[i]) begin
      k = 8'(i);
      ahb(1, 4'h0, rows[i].wd);
      ahb(1, 4'h1, rows[i].bo);
      ahb(1, 4'h2, rows[i].os);
      ahb(1, 4'h5, rows[i].sa);
      ahb(1, 4'h6, 32'h1);
      ahb(1, 4'h7, k);
      ahb(1, 4'h8, 2 * k);
      ahb(1, 4'ha, rows[i].ky);
      rst(n);
      chk("wdog", rows[i].wd, wdog_ctrl);
      chk("brown", {rows[i].bo[7:2], rows[i].sl}, brown_ctrl);
      chk("osc", {(rows[i].fq == 1) ? 16'h1a2b : 16'h3c00, rows[i].os[7],
                  rows[i].fq}, osc_ctrl);
      chk("scope", rows[i].sa[7:6], boot_check_scope);
      chk("pin", rows[i].pn, shared_pin_function);
      chk("locked", rows[i].lk, memory_locked);
      chk("limits", {k, 8'(2 * k), i == 0}, {app_section_limit,
          boot_section_limit, whole_flash_boot});
      chk("drv_off", 0, pin_driver_allowed);
      chk("irq_off", 0, pin_irq_en);
      @(posedge hclk) chip_erase <= 1'b1;
      @(posedge hclk) chip_erase <= 1'b0;
      #1 chk("erase", rows[i].er, eeprom_erase);
      chk("model", rows[i].wd, cfg_wdog);
      ahb(0, 4'hc, 32'h0);
      chk("status", {rows[i].lk, 1'b1}, rd & 32'h3);
      ahb(0, 4'hf, 32'h0);
      chk("unmapped", 0, rd);
      if (rows[i].pn == 2'h0) begin
        m = n + 10;
        while (pin_driver_allowed !== 1'b1 && m < 2000) begin
          @(posedge hclk);
          m++;
        end
        // slow tick may land up to four cycles late against the reset edge
        chk("hold", 1, m >= 768 * 2 && m <= 768 * 2 + 4);
        #1 chk("irq_on", 1, pin_irq_en);
      end
      $display("row %0d done", i);
    end
    ahb(1, 4'h0, 32'h12);
    chk("wdog_live", 8'hff, wdog_ctrl);
    ahb(0, 4'h0, 32'h0);
    chk("wdog_store", 32'h12, rd);
    rst(n);
    chk("wdog_new", 8'h12, wdog_ctrl);
    $display("deferred fuse test done");
    for (int s = 0; s < 8; s++) begin
      ahb(1, 4'h6, s);
      rst(n);
      if (s == 0) base = n;
      else chk("startup", 4 << (s - 1), n - base);
    end
    $display("startup test done");
    give_verdict();
  end
endmodule : tb_fcl_loader
`default_nettype wire
